// [pkg/scx_pkg.sv]
// package for the subroutine call execution block
package scx_pkg;
	localparam int          PC_W          = 16;
	localparam int          ARP_W         = 3;
	localparam int          STACK_DEPTH   = 8;
	localparam int          SP_W          = 3;
	// opcode patterns
	localparam logic [15:0] OP_COMP_CALL  = 16'hbe30;
	localparam logic [15:0] OP_COMP_DIRECT_CALL_DELAYED = 16'hbe3d;
	localparam logic [8:0]  OP_DIR_CALL   = 9'h0f5;
	localparam logic [8:0]  OP_DIR_DIRECT_CALL_DELAYED  = 9'h0fd;
	// return address increments and the one-word pc step
	localparam logic [15:0] INC_DIR       = 16'h0002;
	localparam logic [15:0] INC_DIR_D     = 16'h0004;
	localparam logic [15:0] INC_COMP      = 16'h0001;
	localparam logic [15:0] INC_COMP_D    = 16'h0003;
	localparam logic [15:0] INC_ONE       = 16'h0001;
	// indirect field layout in the first word
	localparam int          IND_BIT       = 7;
	localparam int          NARP_BIT      = 3;
	localparam int          MOD_LSB       = 4;
	// cycle counts, delay slot word count and reset pc
	localparam logic [2:0]  CYC_DIR       = 3'h4;
	localparam logic [2:0]  CYC_DIR_D     = 3'h2;
	localparam logic [2:0]  CYC_COMP      = 3'h4;
	localparam logic [2:0]  CYC_COMP_D    = 3'h2;
	localparam logic [1:0]  DELAY_WORDS   = 2'h2;
	localparam logic [15:0] PC_RESET      = 16'h0000;

	typedef enum logic [2:0] {
		SCX_FETCH,
		SCX_TARGET,
		SCX_FLUSH,
		SCX_SLOT,
		SCX_BRANCH
	} scx_state_t;

	typedef struct packed {
		logic [15:0] word;
		logic        valid;
	} scx_fetch_t;

	typedef struct packed {
		scx_state_t                       st;
		logic [15:0]                      pc;
		logic [15:0]                      target;
		logic [15:0]                      ret;
		logic [2:0]                       cyc;
		logic [1:0]                       slots;
		logic [ARP_W-1:0]                 aux_reg_pointer;
		logic [ARP_W-1:0]                 new_arp;
		logic                             upd_ar;
		logic                             ld_arp;
		logic [2:0]                       ar_mod;
		logic [SP_W-1:0]                  sp;
		logic [STACK_DEPTH-1:0][15:0]     stack;
		logic                             fetch_req;
		logic                             discard;
		logic                             slot_exec;
		logic                             ar_strobe;
		logic                             rpt_reject;
		logic                             busy;
	} scx_regs_t;
endpackage : scx_pkg

// [rtl/scx_call_exec.sv]
// call execution logic: direct and computed calls, delayed and not
`timescale 1ns/10ps
module scx_call_exec
	import scx_pkg::*;
(
	input  wire logic              sys_clk_i,
	input  wire logic              resetn_i,
	input  wire logic [15:0]       pm_word_i,
	input  wire logic              pm_valid_i,
	input  wire logic [31:0]       accumulator_i,
	input  wire logic              single_repeat_i,
	input  wire logic              slot_two_word_i,
	output logic [15:0]            pc_o,
	output logic                   fetch_req_o,
	output logic                   discard_o,
	output logic                   slot_exec_o,
	output logic [15:0]            stack_top_o,
	output logic [ARP_W-1:0]       aux_reg_pointer_o,
	output logic                   aux_register_upd_o,
	output logic [2:0]             aux_register_mod_o,
	output logic                   rpt_reject_o,
	output logic                   busy_o
);
	//////////////////////////////////////////////////////////////////
	logic       rst_meta_r;
	logic       rst_sync_r;
	scx_fetch_t fin;
	scx_regs_t  s_r;
	scx_regs_t  s_nxt;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	assign fin.word  = pm_word_i;
	assign fin.valid = pm_valid_i;

	function automatic logic [15:0] add_pc(input logic [15:0] a, input logic [15:0] b);
		add_pc = 16'(a + b);
	endfunction : add_pc

	//////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt            = s_r;
		s_nxt.ar_strobe  = 1'b0;
		s_nxt.discard    = 1'b0;
		s_nxt.slot_exec  = 1'b0;
		s_nxt.rpt_reject = 1'b0;
		unique case (s_r.st)
			SCX_FETCH: begin
				s_nxt.fetch_req = 1'b1;
				s_nxt.busy      = 1'b0;
				if (fin.valid) begin
					s_nxt.pc = add_pc(s_r.pc, INC_ONE);
					if (fin.word[15:7] == OP_DIR_CALL || fin.word[15:7] == OP_DIR_DIRECT_CALL_DELAYED) begin
						// two-word form: opcode and indirect field, then target
						s_nxt.st      = SCX_TARGET;
						s_nxt.busy    = 1'b1;
						s_nxt.slots   = (fin.word[15:7] == OP_DIR_DIRECT_CALL_DELAYED) ? DELAY_WORDS : 2'h0;
						s_nxt.cyc     = (fin.word[15:7] == OP_DIR_DIRECT_CALL_DELAYED) ? CYC_DIR_D : CYC_DIR;
						s_nxt.ret     = add_pc(s_r.pc, (fin.word[15:7] == OP_DIR_DIRECT_CALL_DELAYED)
							? INC_DIR_D : INC_DIR);
						s_nxt.upd_ar  = fin.word[IND_BIT];
						s_nxt.ld_arp  = fin.word[NARP_BIT];
						s_nxt.new_arp = fin.word[ARP_W-1:0];
						s_nxt.ar_mod  = fin.word[MOD_LSB+2:MOD_LSB];
						s_nxt.rpt_reject = single_repeat_i;
					end else if (fin.word == OP_COMP_CALL || fin.word == OP_COMP_DIRECT_CALL_DELAYED) begin
						// run-time target from the accumulator low half
						s_nxt.target = accumulator_i[15:0];
						s_nxt.upd_ar = 1'b0;
						s_nxt.ld_arp = 1'b0;
						s_nxt.busy   = 1'b1;
						s_nxt.rpt_reject = single_repeat_i;
						if (fin.word == OP_COMP_DIRECT_CALL_DELAYED) begin
							s_nxt.ret   = add_pc(s_r.pc, INC_COMP_D);
							s_nxt.slots = DELAY_WORDS;
							s_nxt.cyc   = CYC_COMP_D;
							s_nxt.st    = SCX_SLOT;
						end else begin
							s_nxt.ret   = add_pc(s_r.pc, INC_COMP);
							s_nxt.slots = 2'h0;
							s_nxt.cyc   = CYC_COMP;
							s_nxt.st    = SCX_FLUSH;
						end
					end
				end
			end
			SCX_TARGET: begin
				if (fin.valid) begin
					s_nxt.target = fin.word;
					s_nxt.pc     = add_pc(s_r.pc, INC_ONE);
					s_nxt.st     = (s_r.slots != 2'h0) ? SCX_SLOT : SCX_FLUSH;
				end
			end
			SCX_FLUSH: begin
				// speculative words are fetched then thrown away
				if (fin.valid) begin
					s_nxt.discard = 1'b1;
					s_nxt.slots   = 2'(s_r.slots + 2'h1);
					if (s_r.slots == 2'h1) begin
						s_nxt.st = SCX_BRANCH;
					end
				end
			end
			SCX_SLOT: begin
				// slot words execute before the branch so their updates land first
				if (fin.valid) begin
					s_nxt.slot_exec = 1'b1;
					s_nxt.pc        = add_pc(s_r.pc, INC_ONE);
					s_nxt.slots     = 2'(s_r.slots - 2'h1);
					if (s_r.slots == 2'h1 || slot_two_word_i) begin
						s_nxt.slots = 2'h0;
						s_nxt.st    = SCX_BRANCH;
						if (slot_two_word_i && s_r.slots == DELAY_WORDS) begin
							s_nxt.st = SCX_SLOT;
							s_nxt.slots = 2'h1;
						end
					end
				end
			end
			SCX_BRANCH: begin
				// push return, then jump
				s_nxt.sp               = 3'(s_r.sp + 3'h1);
				s_nxt.stack[s_nxt.sp]  = s_r.ret;
				s_nxt.pc               = s_r.target;
				s_nxt.slots            = 2'h0;
				s_nxt.st               = SCX_FETCH;
				if (s_r.upd_ar) begin
					s_nxt.ar_strobe = 1'b1;
					if (s_r.ld_arp) begin
						s_nxt.aux_reg_pointer = s_r.new_arp;
					end
				end
			end
			default: s_nxt.st = SCX_FETCH;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			s_r    <= '0;
			s_r.st <= SCX_FETCH;
			s_r.pc <= PC_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////
	assign pc_o               = s_r.pc;
	assign fetch_req_o        = s_r.fetch_req;
	assign discard_o          = s_r.discard;
	assign slot_exec_o        = s_r.slot_exec;
	assign stack_top_o        = s_r.stack[s_r.sp];
	assign aux_reg_pointer_o  = s_r.aux_reg_pointer;
	assign aux_register_upd_o = s_r.ar_strobe;
	assign aux_register_mod_o = s_r.ar_mod;
	assign rpt_reject_o       = s_r.rpt_reject;
	assign busy_o             = s_r.busy;
endmodule : scx_call_exec

// [dv/scx_call_monitor.sv]
// assertion checker for the call execution block
`timescale 1ns/10ps
module scx_call_monitor
	import scx_pkg::*;
(
	input wire logic        sys_clk_i,
	input wire logic        resetn_i,
	input wire logic [15:0] pm_word_i,
	input wire logic        pm_valid_i,
	input wire logic [31:0] accumulator_i,
	input wire logic        single_repeat_i,
	input wire logic [15:0] pc_o,
	input wire logic        discard_o,
	input wire logic        slot_exec_o,
	input wire logic [15:0] stack_top_o,
	input wire logic [2:0]  aux_reg_pointer_o,
	input wire logic        aux_register_upd_o,
	input wire logic [2:0]  aux_register_mod_o,
	input wire logic        rpt_reject_o,
	input wire logic        busy_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	// a call is only recognised on an idle cycle
	wire go = pm_valid_i && !busy_o;
	wire dc = go && pm_word_i[15:7] == OP_DIR_CALL;
	wire dd = go && pm_word_i[15:7] == OP_DIR_DIRECT_CALL_DELAYED;
	wire cc = go && pm_word_i == OP_COMP_CALL;
	wire cd = go && pm_word_i == OP_COMP_DIRECT_CALL_DELAYED;
	property p_ret_dir; dc |-> ##5 stack_top_o == $past(pc_o, 5) + INC_DIR; endproperty
	a_ret_dir: assert property (p_ret_dir) else $error("direct return address wrong");
	property p_tgt_dir; dc ##1 pm_valid_i |-> ##4 pc_o == $past(pm_word_i, 4); endproperty
	a_tgt_dir: assert property (p_tgt_dir) else $error("direct target not loaded");
	property p_arp; dc && pm_word_i[3] |-> ##5 aux_reg_pointer_o == $past(pm_word_i[2:0], 5);
	endproperty
	a_arp: assert property (p_arp) else $error("pointer not loaded");
	property p_ar_upd; dc |-> ##5 aux_register_upd_o; endproperty
	a_ar_upd: assert property (p_ar_upd) else $error("aux register not modified");
	property p_ar_mod; dc |=> aux_register_mod_o == $past(pm_word_i[6:4]); endproperty
	a_ar_mod: assert property (p_ar_mod) else $error("aux modify code wrong");
	property p_slot; dd |-> ##3 (slot_exec_o && !discard_o) ##1 slot_exec_o; endproperty
	a_slot: assert property (p_slot) else $error("delay slots not run");
	property p_ret_dd; dd |-> ##5 stack_top_o == $past(pc_o, 5) + INC_DIR_D; endproperty
	a_ret_dd: assert property (p_ret_dd) else $error("delayed return address wrong");
	property p_disc; dc |-> ##3 discard_o [*2]; endproperty
	a_disc: assert property (p_disc) else $error("speculative words not dropped");
	property p_rpt; (dc || dd || cc || cd) && single_repeat_i |=> rpt_reject_o; endproperty
	a_rpt: assert property (p_rpt) else $error("repeated call not refused");
	property p_comp;
		cc |-> ##4 pc_o == $past(accumulator_i[15:0], 4) && stack_top_o == $past(pc_o, 4) + INC_COMP;
	endproperty
	a_comp: assert property (p_comp) else $error("computed call wrong");
	property p_comp_d;
		cd |-> ##4 pc_o == $past(accumulator_i[15:0], 4) && stack_top_o == $past(pc_o, 4) + INC_COMP_D;
	endproperty
	a_comp_d: assert property (p_comp_d) else $error("delayed computed call wrong");
	c_dc: cover property (dc);
	c_dd: cover property (dd);
	c_cd: cover property (cd);
	c_rej: cover property (rpt_reject_o);
endmodule : scx_call_monitor

bind scx_call_exec scx_call_monitor u_mon (.*);

// [dv/scx_pm_model.sv]
// program memory model feeding instruction words on fetch request
`timescale 1ns/10ps
module scx_pm_model (
	input  wire logic       clk_i,
	input  wire logic       fetch_req_i,
	input  wire logic [2:0] len_i,
	output logic [15:0]     word_o,
	output logic            valid_o
);
	logic [15:0] mem [0:3];
	logic [2:0]  idx;
	initial begin
		word_o = 16'h0000;
		valid_o = 1'b0;
		idx = 3'h0;
	end
	// idle bus toggles every cycle between the inverse of the last word and the last word itself
	always @(negedge clk_i) begin
		if (len_i != 3'h0 && fetch_req_i && idx < len_i) begin
			word_o <= mem[idx[1:0]];
			valid_o <= 1'b1;
			idx <= idx + 3'h1;
		end else begin
			word_o <= ~word_o;
			valid_o <= 1'b0;
			if (len_i == 3'h0) idx <= 3'h0;
		end
	end
endmodule : scx_pm_model

// [dv/subroutine_call_exec_bench.sv]
// self-checking bench for the call execution block
`timescale 1ns/10ps
module subroutine_call_exec_bench
	import scx_pkg::*;
;
	logic sys_clk_i = 0, resetn_i = 0, pm_valid_i, single_repeat_i = 0, slot_two_word_i = 0;
	logic [15:0] pm_word_i, pc_o, stack_top_o, p;
	logic [31:0] accumulator_i = 32'h0;
	logic fetch_req_o, discard_o, slot_exec_o, aux_register_upd_o, rpt_reject_o, busy_o, rj;
	logic [2:0] aux_reg_pointer_o, aux_register_mod_o, len = 3'h0;
	int n_mismatch = 0, compares = 0;
	int nd, ns, na;
	scx_call_exec uut (.*);
	scx_pm_model pm (.clk_i(sys_clk_i), .fetch_req_i(fetch_req_o), .len_i(len),
		.word_o(pm_word_i), .valid_o(pm_valid_i));
	initial forever #2 sys_clk_i = ~sys_clk_i;
	task summarize();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// feeds n words, then waits for the call to finish under a bound
	task automatic run(input logic [15:0] a, b, c, d, input logic [2:0] n);
		int i;
		logic seen;
		p = pc_o;
		rj = 0;
		nd = 0;
		ns = 0;
		na = 0;
		seen = 0;
		pm.mem[0] = a; pm.mem[1] = b; pm.mem[2] = c; pm.mem[3] = d;
		@(negedge sys_clk_i) len <= n;
		for (i = 0; i < 30 && !(seen && !busy_o); i++) begin
			@(posedge sys_clk_i) #1;
			seen |= busy_o;
			rj |= rpt_reject_o;
			nd += discard_o;
			ns += slot_exec_o;
			na += aux_register_upd_o;
		end
		if (i == 30) begin n_mismatch++; summarize(); end
		@(negedge sys_clk_i) len <= 3'h0;
		@(negedge sys_clk_i);
	endtask : run
	task s_direct();
		run(16'h7a9d, 16'h00bf, 16'h1111, 16'h2222, 3'h4);
		chk(pc_o, 16'h00bf);
		chk(stack_top_o, p + INC_DIR);
		chk({13'h0, aux_reg_pointer_o}, 16'h0005);
		chk(16'(na), 16'h0001);
		chk({13'h0, aux_register_mod_o}, 16'h0001);
		chk(16'(nd), 16'h0002);
		chk({15'h0, rj}, 16'h0000);
	endtask : s_direct
	task s_direct_d();
		@(negedge sys_clk_i) slot_two_word_i = 1;
		run(16'h7e80, 16'h1234, 16'h3333, 16'h4444, 3'h4);
		chk(pc_o, 16'h1234);
		chk(16'(ns), 16'h0002);
		chk(16'(nd), 16'h0000);
		chk(stack_top_o, p + INC_DIR_D);
		slot_two_word_i = 0;
	endtask : s_direct_d
	task s_comp();
		@(negedge sys_clk_i) accumulator_i = 32'h00000083;
		run(OP_COMP_CALL, 16'h5555, 16'h6666, 16'h0, 3'h3);
		chk(pc_o, 16'h0083);
		chk(stack_top_o, p + INC_COMP);
		chk(16'(nd), 16'h0002);
		chk(16'(na), 16'h0000);
	endtask : s_comp
	task s_comp_d();
		@(negedge sys_clk_i) accumulator_i = 32'hffff4321;
		run(OP_COMP_DIRECT_CALL_DELAYED, 16'h7777, 16'h0888, 16'h0, 3'h3);
		chk(pc_o, 16'h4321);
		chk(stack_top_o, p + INC_COMP_D);
		chk(16'(ns), 16'h0002);
	endtask : s_comp_d
	task s_rpt();
		@(negedge sys_clk_i) single_repeat_i = 1;
		run(OP_COMP_CALL, 16'h5555, 16'h6666, 16'h0, 3'h3);
		chk({15'h0, rj}, 16'h0001);
		chk({15'h0, busy_o}, 16'h0000);
		single_repeat_i = 0;
	endtask : s_rpt
	initial begin
		repeat (3) @(posedge sys_clk_i);
		@(negedge sys_clk_i) resetn_i = 1;
		repeat (4) @(negedge sys_clk_i);
		chk({15'h0, fetch_req_o}, 16'h0001);
		s_direct();
		s_direct_d();
		s_comp();
		s_comp_d();
		s_rpt();
		summarize();
	end
endmodule : subroutine_call_exec_bench
